// ===== pkg/adc_ctrl_pkg.sv
// shared constants and types of the dual converter control block
// assumes a 100 MHz register clock and pins that change slowly against it
package adc_ctrl_pkg;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int RES_BITS = 12;                   // bits of one converter result
  localparam logic [11:0] CODE_OFFSET = 12'h800;  // two's complement to offset binary
  localparam int CLK_PERIOD_NS = 10;              // pclk period
  localparam int OSC_PERIOD_NS = 40;              // internal bit-decision oscillator period
  // least time, so rounded up; never below one cycle
  localparam logic [7:0] OSC_DIV = 8'((OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] WORD_BITS = 5'h0C;       // serial clocks per result
  localparam logic [4:0] READ_BITS = 5'h18;       // both results back to back

  // ************************************************************
  // register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [11:0] REG_STATUS = 12'h000;   // sticky events, read clears
  localparam logic [11:0] REG_MASK = 12'h004;     // event enables
  localparam logic [11:0] REG_RESULT = 12'h008;   // last results, first in 11:0
  localparam logic [11:0] REG_STATE = 12'h00C;    // live state of the block
  localparam int RESULT_SECOND_POS = 16;          // second result field position

  // event bit positions, shared by status and mask
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;                     // conversion finished
  localparam int EV_PDOWN = 1;                    // power-down entered
  localparam int EV_READ = 2;                     // serial read closed after a word
  localparam logic [2:0] MASK_RESET = 3'h0;

  // state register field positions
  localparam int STF_BUSY = 0;
  localparam int STF_PDOWN = 1;
  localparam int STF_CHAN = 2;
  localparam int STF_REF = 3;
  localparam int STF_SPAN = 4;                    // two bits

  // synchroniser reset value: trigger, chip select and parked serial clock idle high,
  // so no false edge follows reset
  localparam logic [6:0] SYNC_RESET = 7'h07;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONVERT = 2'b01,
    ST_POWERDOWN = 2'b11
  } conv_state_t;

  typedef enum logic [1:0] {
    SPAN_BIP10 = 2'b00,
    SPAN_BIP5 = 2'b01,
    SPAN_UNI10 = 2'b10,
    SPAN_UNUSED = 2'b11
  } span_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
  } serial_in_t;

  typedef struct packed {
    logic [11:0] ch2;
    logic [11:0] ch1;
  } channel_pair_t;

  typedef struct packed {
    logic [11:0] second;
    logic [11:0] first;
  } result_pair_t;

endpackage

// ===== core/sar_core.sv
// one successive approximation converter, bit decisions on an enable tick
// assumes start is a one-cycle pulse and tick comes from the internal divider
`timescale 1ns/1ns
module sar_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [11:0] sample,
  // answer
  output logic active,
  output logic done,
  output logic [11:0] result
);

  logic [11:0] target;  // held value in offset binary
  logic [11:0] trial;   // bits decided so far
  logic [11:0] probe;   // bit under test
  logic [11:0] cand;    // trial with the probe bit set

  assign cand = trial | probe;

  // ************************************************************
  // bit decisions
  // ************************************************************
  // one decision per tick, msb first; the last decision ends the run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target <= 12'h000;
      trial <= 12'h000;
      probe <= 12'h000;
      active <= 1'b0;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        target <= sample ^ adc_ctrl_pkg::CODE_OFFSET;
        trial <= 12'h000;
        probe <= 12'h800;
        active <= 1'b1;
      end else if (active && tick) begin
        // keep the bit when the trial does not pass the held value
        if (cand <= target) begin
          trial <= cand;
        end
        probe <= probe >> 1;
        if (probe == 12'h001) begin
          active <= 1'b0;
          done <= 1'b1;
          result <= ((cand <= target) ? cand : trial) ^ adc_ctrl_pkg::CODE_OFFSET;
        end
      end
    end
  end

  // finished code must equal the held sample exactly
  property p_sar_exact;
    @(posedge clk) disable iff (!rst_n)
    done |-> (result == (target ^ adc_ctrl_pkg::CODE_OFFSET));
  endproperty
  a_sar_exact: assert property (p_sar_exact) else $error("result differs from held sample");

endmodule

// ===== core/dual_conv_ctrl.sv
// control of a dual 12-bit converter: trigger, busy, serial read, apb registers
// assumes pins are asynchronous to pclk and the serial clock is far slower than pclk
`timescale 1ns/1ns

// Summary of operation
// - two 12-bit converters, one shared trigger
// - two single-ended channels per converter
// - trigger falling edge: hold and start both
// - busy high while conversions run
// - busy low when conversions end
// - busy falling returns holds to track
// - bit decisions timed by internal oscillator
// - serial shifting only after conversion finished
// - two data lines, one per converter
// - reference select high: internal reference
// - reference select low: external reference
// - span code selects input span
// - channel select latched at busy rising
// - chip select low enables twelve-clock words
// - trigger low at end: power down
// - results in two's complement
module dual_conv_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // conversion pins
  input wire logic sample_trigger_n,
  input wire logic channel_select,
  input wire logic span_select_lo,
  input wire logic span_select_hi,
  input wire logic reference_source_select,
  output logic busy,
  // analog front end, levels as codes
  input wire adc_ctrl_pkg::channel_pair_t input_first,
  input wire adc_ctrl_pkg::channel_pair_t input_second,
  output logic track_hold_hold,
  output logic internal_reference_en,
  output adc_ctrl_pkg::span_t span_applied,
  output logic powered_down,
  // serial link
  input wire adc_ctrl_pkg::serial_in_t serial_in,
  output logic result_line_first,
  output logic result_line_first_oe,
  output logic result_line_second,
  output logic result_line_second_oe
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [6:0] pins_meta;  // first stage, read only by the second
  logic [6:0] pins_sync;
  logic [47:0] level_meta;
  logic [47:0] level_sync;
  logic trig_s, cs_s, sclk_s, chsel_s, ref_s;
  logic [1:0] span_s;
  logic trig_d, cs_d, sclk_d;  // previous synchronised levels for edges
  logic trig_fall, trig_rise, cs_fall, cs_rise, sclk_fall;

  // two flops for every pin before any logic sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= adc_ctrl_pkg::SYNC_RESET;
      pins_sync <= adc_ctrl_pkg::SYNC_RESET;
      level_meta <= 48'h000000000000;
      level_sync <= 48'h000000000000;
    end else begin
      pins_meta <= {span_select_hi, span_select_lo, reference_source_select, channel_select,
                    serial_in.sclk, serial_in.cs_n, sample_trigger_n};
      pins_sync <= pins_meta;
      // input levels are quasi-static while tracking, so a plain pair of flops serves
      level_meta <= {input_second, input_first};
      level_sync <= level_meta;
    end
  end

  assign trig_s = pins_sync[0];
  assign cs_s = pins_sync[1];
  assign sclk_s = pins_sync[2];
  assign chsel_s = pins_sync[3];
  assign ref_s = pins_sync[4];
  assign span_s = pins_sync[6:5];

  // edge detection on the synchronised levels only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d <= 1'b1;
      cs_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      trig_d <= trig_s;
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  assign trig_fall = trig_d & ~trig_s;
  assign trig_rise = ~trig_d & trig_s;
  assign cs_fall = cs_d & ~cs_s;
  assign cs_rise = ~cs_d & cs_s;
  assign sclk_fall = sclk_d & ~sclk_s;

  // ************************************************************
  // internal oscillator and converters
  // ************************************************************
  adc_ctrl_pkg::conv_state_t state;
  logic start;          // one-cycle start of both converters
  logic [7:0] osc_cnt;  // divider of the internal oscillator
  logic osc_tick;
  logic chan_sel;       // channel pair for the next conversion
  logic [11:0] pick_first, pick_second;
  logic done_first, done_second, act_first, act_second;
  adc_ctrl_pkg::result_pair_t res_now;  // converter outputs
  adc_ctrl_pkg::result_pair_t res_last; // results kept for reading

  assign start = (state == adc_ctrl_pkg::ST_TRACK) && trig_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else if (state != adc_ctrl_pkg::ST_CONVERT) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (osc_cnt == adc_ctrl_pkg::OSC_DIV - 8'h01);
      osc_cnt <= (osc_cnt == adc_ctrl_pkg::OSC_DIV - 8'h01) ? 8'h00 : osc_cnt + 8'h01;
    end
  end

  // two single-ended channels on each converter
  assign pick_first = chan_sel ? level_sync[23:12] : level_sync[11:0];
  assign pick_second = chan_sel ? level_sync[47:36] : level_sync[35:24];

  sar_core conv_first (
    .clk(pclk),
    .rst_n(presetn),
    .start(start),
    .tick(osc_tick),
    .sample(pick_first),
    .active(act_first),
    .done(done_first),
    .result(res_now.first)
  );

  sar_core conv_second (
    .clk(pclk),
    .rst_n(presetn),
    .start(start),
    .tick(osc_tick),
    .sample(pick_second),
    .active(act_second),
    .done(done_second),
    .result(res_now.second)
  );

  // results become readable only once both are done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_last <= 24'h000000;
    end else if (done_first) begin
      res_last <= res_now;
    end
  end

  // ************************************************************
  // conversion sequence
  // ************************************************************
  // track, convert, optional power-down; busy and hold follow the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adc_ctrl_pkg::ST_TRACK;
      busy <= 1'b0;
      track_hold_hold <= 1'b0;
      powered_down <= 1'b0;
    end else begin
      case (state)
        adc_ctrl_pkg::ST_TRACK: begin
          if (trig_fall) begin
            state <= adc_ctrl_pkg::ST_CONVERT;
            track_hold_hold <= 1'b1;
            busy <= 1'b1;
          end
        end
        adc_ctrl_pkg::ST_CONVERT: begin
          if (done_first) begin
            busy <= 1'b0;
            track_hold_hold <= 1'b0;
            if (!trig_s) begin
              state <= adc_ctrl_pkg::ST_POWERDOWN;
              powered_down <= 1'b1;
            end else begin
              state <= adc_ctrl_pkg::ST_TRACK;
            end
          end
        end
        adc_ctrl_pkg::ST_POWERDOWN: begin
          if (trig_rise) begin
            state <= adc_ctrl_pkg::ST_TRACK;
            powered_down <= 1'b0;
          end
        end
        default: begin
          state <= adc_ctrl_pkg::ST_TRACK;
          busy <= 1'b0;
          track_hold_hold <= 1'b0;
          powered_down <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_sel <= 1'b0;
    end else if (start) begin
      // the start cycle is the edge on which busy rises; this sample has already
      // been taken, so the new pair applies to the following conversion
      chan_sel <= chsel_s;
    end
  end

  // span taken at hold, code 11 keeps the old span
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_applied <= adc_ctrl_pkg::SPAN_BIP10;
    end else if (start && span_s != adc_ctrl_pkg::SPAN_UNUSED) begin
      span_applied <= adc_ctrl_pkg::span_t'(span_s);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_reference_en <= 1'b0;
    end else begin
      internal_reference_en <= ref_s;
    end
  end

  // ************************************************************
  // serial read
  // ************************************************************
  logic [23:0] shift_first, shift_second;
  logic [4:0] bit_cnt;  // serial clocks seen in this frame

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_line_first_oe <= 1'b0;
      result_line_second_oe <= 1'b0;
    end else begin
      result_line_first_oe <= ~cs_s;
      result_line_second_oe <= ~cs_s;
    end
  end

  // each line starts with its own converter, then the other one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_first <= 24'h000000;
      shift_second <= 24'h000000;
      bit_cnt <= 5'h00;
    end else if (cs_fall) begin
      shift_first <= {res_last.first, res_last.second};
      shift_second <= {res_last.second, res_last.first};
      bit_cnt <= 5'h00;
    end else if (!cs_s && sclk_fall && !busy && bit_cnt != adc_ctrl_pkg::READ_BITS) begin
      shift_first <= {shift_first[22:0], 1'b0};
      shift_second <= {shift_second[22:0], 1'b0};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // line levels registered from the shift msb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_line_first <= 1'b0;
      result_line_second <= 1'b0;
    end else begin
      result_line_first <= shift_first[23];
      result_line_second <= shift_second[23];
    end
  end

  // ************************************************************
  // events, apb registers and interrupt
  // ************************************************************
  logic [2:0] status, mask, events, clr_bits;
  logic setup, access_wr, access_rd;

  assign events = {cs_rise && bit_cnt >= adc_ctrl_pkg::WORD_BITS,
                   done_first && !trig_s, done_first};
  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pready & pwrite;
  assign access_rd = psel & penable & pready & ~pwrite;
  // only the bits shown to software are cleared, so a new event is never lost
  assign clr_bits = (access_rd && paddr == adc_ctrl_pkg::REG_STATUS) ? prdata[2:0] : 3'h0;

  // sticky status, set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~clr_bits) | events;
    end
  end

  // mask register, the only writable one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= adc_ctrl_pkg::MASK_RESET;
    end else if (access_wr && paddr == adc_ctrl_pkg::REG_MASK) begin
      mask <= pwdata[2:0];
    end
  end

  // fixed zero-wait answer: data and ready set up during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (setup) begin
        case (paddr)
          adc_ctrl_pkg::REG_STATUS: prdata <= {29'h0, status};
          adc_ctrl_pkg::REG_MASK: prdata <= {29'h0, mask};
          adc_ctrl_pkg::REG_RESULT: prdata <= {4'h0, res_last.second, 4'h0, res_last.first};
          adc_ctrl_pkg::REG_STATE: prdata <= {26'h0, span_applied, internal_reference_en,
                                             chan_sel, powered_down, busy};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // level interrupt from any unmasked sticky bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_trig_start;
    start |=> busy && track_hold_hold ##1 (act_first && act_second);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

  property p_busy_stays;
    busy && !done_first |=> busy;
  endproperty
  a_busy_stays: assert property (p_busy_stays) else $error("busy dropped early");

  property p_busy_ends;
    done_first |=> !busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy stayed after end");

  property p_track_back;
    $fell(busy) |-> !track_hold_hold;
  endproperty
  a_track_back: assert property (p_track_back) else $error("hold kept after busy");

  property p_both_done;
    done_first == done_second;
  endproperty
  a_both_done: assert property (p_both_done) else $error("converters out of step");

  property p_powerdown;
    done_first && !trig_s |=> powered_down ##0 (state == adc_ctrl_pkg::ST_POWERDOWN);
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("no power down");

  property p_chan_latch;
    $rose(busy) |-> chan_sel == $past(chsel_s);
  endproperty
  a_chan_latch: assert property (p_chan_latch) else $error("channel not latched");

  property p_no_shift_busy;
    busy && !cs_fall |=> shift_first == $past(shift_first);
  endproperty
  a_no_shift_busy: assert property (p_no_shift_busy) else $error("shift while busy");

  property p_irq;
    ##1 irq == $past(|(status & mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_ref;
    ##1 internal_reference_en == $past(ref_s);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not followed");

endmodule

// ===== sim/host_model.sv
// host side model: trigger pin and serial reader of both result lines
// assumes pclk from the bench; sclk runs only inside frames, 160 ns period
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic pclk,
  // pins toward the device
  output logic sample_trigger_n,
  output adc_ctrl_pkg::serial_in_t serial_in,
  // serial data from the device
  input wire logic line_a,
  input wire logic line_b,
  input wire logic oe_a,
  input wire logic oe_b
);
  // idle: trigger and chip select high, sclk parked high between frames
  initial begin
    sample_trigger_n = 1'b1;
    serial_in = 2'h3;
  end

  // trigger level, changed just after an edge
  task automatic set_trig(input logic v);
    @(posedge pclk);
    sample_trigger_n <= v;
  endtask

  // ************************************************************
  // serial frame
  // ************************************************************
  // read after busy, two whole words
  task automatic read_frame(output logic [23:0] a, output logic [23:0] b, output logic ok);
    ok = 1'b1;
    @(posedge pclk);
    // pins move only right after a pclk edge; 8 + 8 cycles make the 160 ns sclk
    serial_in.cs_n <= 1'b0;
    repeat (8) @(posedge pclk);
    repeat (24) begin
      a = {a[22:0], line_a};
      b = {b[22:0], line_b};
      ok = ok & oe_a & oe_b;
      serial_in.sclk <= 1'b0;
      repeat (8) @(posedge pclk);
      serial_in.sclk <= 1'b1;
      repeat (8) @(posedge pclk);
    end
    serial_in.cs_n <= 1'b1;
  endtask
endmodule

// ===== sim/tb_dual_conv_ctrl.sv
// self-checking bench of the dual converter control block
// assumes the host model drives trigger and serial pins
`timescale 1ns/1ns
module tb_dual_conv_ctrl;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, busy, hold, iref, pdown, err, ok;
  logic chan = 1'b0;
  logic sp_lo = 1'b0;
  logic sp_hi = 1'b0;
  logic ref_sel = 1'b1;
  adc_ctrl_pkg::channel_pair_t in_a = {12'h9AB, 12'h123};
  adc_ctrl_pkg::channel_pair_t in_b = {12'h045, 12'hF00};
  adc_ctrl_pkg::span_t span;
  adc_ctrl_pkg::serial_in_t ser;
  logic trig_n, la, lb, oa, ob;
  logic [23:0] wa, wb;
  int fails = 0;
  int num_checks = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  dual_conv_ctrl dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sample_trigger_n(trig_n), .channel_select(chan),
    .span_select_lo(sp_lo), .span_select_hi(sp_hi), .reference_source_select(ref_sel),
    .busy(busy), .input_first(in_a), .input_second(in_b), .track_hold_hold(hold),
    .internal_reference_en(iref), .span_applied(span), .powered_down(pdown),
    .serial_in(ser), .result_line_first(la), .result_line_first_oe(oa),
    .result_line_second(lb), .result_line_second_oe(ob)
  );

  host_model host (
    .pclk(pclk), .sample_trigger_n(trig_n), .serial_in(ser),
    .line_a(la), .line_b(lb), .oe_a(oa), .oe_b(ob)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one conversion; stay keeps the trigger low past its end
  task automatic conv(input logic stay);
    int n;
    n = 0;
    host.set_trig(1'b0);
    while (busy !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check(n < 8, 1'b1);
    check(hold, 1'b1);
    if (!stay) host.set_trig(1'b1);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(n >= 44 && n <= 52, 1'b1);
    check(hold, 1'b0);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    repeat (5) @(posedge pclk);
    check({busy, hold, pdown, irq, oa, ob}, 32'h0);
    apb(1'b0, adc_ctrl_pkg::REG_STATE, 32'h0);
    check(rd, 32'h8);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask

  task automatic t_data;
    chan <= 1'b1;
    conv(1'b0);
    apb(1'b0, adc_ctrl_pkg::REG_RESULT, 32'h0);
    check(rd, 32'h0F00_0123);
    host.read_frame(wa, wb, ok);
    check({8'h0, wa}, 32'h0012_3F00);
    check({8'h0, wb}, 32'h00F0_0123);
    check(ok, 1'b1);
    repeat (6) @(posedge pclk);
    check({oa, ob}, 32'h0);
    conv(1'b0);
    apb(1'b0, adc_ctrl_pkg::REG_RESULT, 32'h0);
    check(rd, 32'h0045_09AB);
  endtask

  task automatic t_span;
    for (int c = 0; c < 3; c++) begin
      // set between conversions; code 11 never driven
      {sp_hi, sp_lo} <= c[1:0];
      ref_sel <= c[0];
      repeat (5) @(posedge pclk);
      conv(1'b0);
      check(span, c[1:0]);
      check(iref, c[0]);
    end
  endtask

  task automatic t_pdown;
    apb(1'b0, adc_ctrl_pkg::REG_STATUS, 32'h0);
    conv(1'b1);
    repeat (3) @(posedge pclk);
    check(pdown, 1'b1);
    apb(1'b0, adc_ctrl_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h3);
    host.set_trig(1'b1);
    repeat (6) @(posedge pclk);
    check(pdown, 1'b0);
  endtask

  task automatic t_irq;
    apb(1'b1, adc_ctrl_pkg::REG_MASK, 32'h1);
    apb(1'b0, adc_ctrl_pkg::REG_MASK, 32'h0);
    check(rd, 32'h1);
    conv(1'b0);
    repeat (3) @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b0, adc_ctrl_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h1);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b1, adc_ctrl_pkg::REG_MASK, 32'h0);
    conv(1'b0);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
  endtask

  task automatic test_done;
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_data;
    t_span;
    t_pdown;
    t_irq;
    test_done;
  end

  // watchdog at about five times the expected run of some 1000 cycles
  initial begin
    #50000;
    fails++;
    test_done;
  end
endmodule
